// ===== common/cbm_pkg.sv
package cbm_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] MASK_ADDR = 8'h2C; // balance_event_mask offset
    localparam logic [7:0] FLAG_ADDR = 8'h2B; // event flag register offset
    localparam logic [7:0] MASK_RESET = 8'h00; // mask reset value
    localparam logic [7:0] FLAG_RESET = 8'h00; // flag reset value
    localparam logic [7:0] MASK_WRITABLE = 8'h3F; // bits 7:6 reserved
    // ****************************************************************
    // field positions, shared by mask and flag registers
    // ****************************************************************
    localparam int EV_OVERCURRENT = 0; // balance_overcurrent
    localparam int EV_LOWER_OV = 1; // lower_overvolt
    localparam int EV_UPPER_OV = 2; // upper_overvolt
    localparam int EV_LOWER_CV = 3; // lower_const_volt
    localparam int EV_UPPER_CV = 4; // upper_const_volt
    localparam int EV_TRANSITION = 5; // balance_transition
    localparam int EV_COUNT = 6; // number of event sources
    // ****************************************************************
    // alert pulse timing
    // ****************************************************************
    localparam int ALERT_PULSE_CYCLES = 1; // low time of alert pin
endpackage

// ===== common/cbm_event_if.sv
`timescale 1ns/1ps
// carries latched flags and new event pulses between modules
interface cbm_event_if;
    import cbm_pkg::*;
    logic [EV_COUNT-1:0] flags; // latched event flags
    logic [EV_COUNT-1:0] newEvent; // one-cycle pulse per fresh event
    modport source (output flags, output newEvent);
    modport sink (input flags, input newEvent);
endinterface

// ===== hw/cbm_event_latch.sv
`timescale 1ns/1ps
// latches event flags; flags clear on host read, set wins over clear
module cbm_event_latch (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // raw conditions from balancing logic
    input wire logic [cbm_pkg::EV_COUNT-1:0] condLevel,
    // clear request from register read
    input wire logic flagReadClr,
    // outgoing flags and events
    cbm_event_if.source ev
);
    import cbm_pkg::*;

    // ****************************************************************
    // edge detection on conditions
    // ****************************************************************
    logic [EV_COUNT-1:0] condPrev_ff; // condition one cycle ago
    logic [EV_COUNT-1:0] flags_ff; // sticky flags
    logic [EV_COUNT-1:0] rise; // new event pulses

    // previous condition levels
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            condPrev_ff <= '0;
        end else begin
            condPrev_ff <= condLevel;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < EV_COUNT; gi++) begin : g_ev
            if (gi == EV_TRANSITION) begin : g_both
                // transition counts entry and exit alike
                assign rise[gi] = condLevel[gi] ^ condPrev_ff[gi];
            end else begin : g_rise
                // fresh start of a held condition
                assign rise[gi] = condLevel[gi] & ~condPrev_ff[gi];
            end
        end
    endgenerate

    // ****************************************************************
    // sticky flags
    // ****************************************************************
    // a condition other than transition still present keeps its flag set even through a read,
    // so an ongoing fault is never reported as gone
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flags_ff <= FLAG_RESET[EV_COUNT-1:0];
        end else if (flagReadClr) begin
            flags_ff <= rise | (condLevel & ~(EV_COUNT'(1) << EV_TRANSITION));
        end else begin
            flags_ff <= flags_ff | rise | (condLevel & ~(EV_COUNT'(1) << EV_TRANSITION));
        end
    end

    assign ev.flags = flags_ff;
    assign ev.newEvent = rise;

    // a fresh upper overvolt event always lands in the flag next cycle
    a_flag_sets_event: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rise[EV_UPPER_OV] |=> flags_ff[EV_UPPER_OV])
        else $error("upper overvolt event not latched");
endmodule

// ===== hw/cbm_top.sv
`timescale 1ns/1ps
// Function
// - 8-bit mask at 2Ch, resets to zero
// - bits 7 and 6 read zero
// - transition mask stops balance entry/exit alert
// - upper CV mask stops its alert
// - lower CV mask stops its alert
// - upper overvolt mask stops its alert
// - lower overvolt mask stops its alert
// - overcurrent mask stops its alert
// - transition flag sets on entry or exit
// - flags stay set, clear on read unless a condition other than transition is still held
module cbm_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port from serial bus engine
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // balancing conditions from analogue side
    input wire logic balanceActive,
    input wire logic upperConstVolt,
    input wire logic lowerConstVolt,
    input wire logic upperOvervolt,
    input wire logic lowerOvervolt,
    input wire logic balanceOvercurrent,
    // host alert pin, pulses low
    output logic alert_n
);
    import cbm_pkg::*;

    // ****************************************************************
    // event latch
    // ****************************************************************
    cbm_event_if evBus ();
    logic [EV_COUNT-1:0] condLevel; // packed conditions
    logic flagReadClr; // host reading flag register

    assign condLevel[EV_TRANSITION] = balanceActive;
    assign condLevel[EV_UPPER_CV] = upperConstVolt;
    assign condLevel[EV_LOWER_CV] = lowerConstVolt;
    assign condLevel[EV_UPPER_OV] = upperOvervolt;
    assign condLevel[EV_LOWER_OV] = lowerOvervolt;
    assign condLevel[EV_OVERCURRENT] = balanceOvercurrent;
    assign flagReadClr = regRead && (regAddr == FLAG_ADDR);

    cbm_event_latch uLatch (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .condLevel(condLevel),
        .flagReadClr(flagReadClr),
        .ev(evBus.source)
    );

    // ****************************************************************
    // mask register
    // ****************************************************************
    logic [7:0] mask_ff; // balance_event_mask
    logic [EV_COUNT-1:0] unmaskedEvent; // events allowed to alert

    // reserved bits are never stored, whatever the host writes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mask_ff <= MASK_RESET;
        end else if (regWrite && regAddr == MASK_ADDR) begin
            mask_ff <= regWdata & MASK_WRITABLE;
        end
    end

    // each mask bit gates only its own source; flags are untouched
    assign unmaskedEvent = evBus.newEvent & ~mask_ff[EV_COUNT-1:0];

    // ****************************************************************
    // alert pulse
    // ****************************************************************
    logic [1:0] pulseCnt_ff; // remaining low cycles

    // a new event restarts the pulse; back-to-back events merge
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pulseCnt_ff <= '0;
        end else if (|unmaskedEvent) begin
            pulseCnt_ff <= 2'(ALERT_PULSE_CYCLES);
        end else if (pulseCnt_ff != '0) begin
            pulseCnt_ff <= pulseCnt_ff - 2'd1;
        end
    end

    // alert pin registered, low on the event edge and while the count runs on
    // a width above one cycle keeps the pin low for the remaining count
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            alert_n <= 1'b1;
        end else begin
            alert_n <= !((|unmaskedEvent) || (pulseCnt_ff > 2'd1));
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    // registered read; unmapped addresses return zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else if (regRead && regAddr == MASK_ADDR) begin
            regRdata <= {2'b00, mask_ff[5:0]};
        end else if (regRead && regAddr == FLAG_ADDR) begin
            regRdata <= {2'b00, evBus.flags};
        end else if (regRead) begin
            regRdata <= '0;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_mask_reset_zero: assert property (@(posedge clk_sys)
        !rst_n |=> mask_ff == 8'h00)
        else $error("mask not zero after reset");
    a_reserved_read_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(regRead) |-> regRdata[7:6] == 2'b00)
        else $error("reserved bits read nonzero");
    a_transition_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent == 6'h20 && mask_ff[5]) |=> alert_n)
        else $error("masked transition pulsed alert");
    a_upper_cv_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent == 6'h10 && mask_ff[4]) |=> alert_n)
        else $error("masked upper cv pulsed alert");
    a_lower_cv_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent == 6'h08 && mask_ff[3]) |=> alert_n)
        else $error("masked lower cv pulsed alert");
    a_upper_ov_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent == 6'h04 && mask_ff[2]) |=> alert_n)
        else $error("masked upper ov pulsed alert");
    a_lower_ov_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent == 6'h02 && mask_ff[1]) |=> alert_n)
        else $error("masked lower ov pulsed alert");
    a_overcurrent_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent == 6'h01 && mask_ff[0]) |=> alert_n)
        else $error("masked overcurrent pulsed alert");
    a_unmasked_alerts: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent[5] && !mask_ff[5]) |=> !alert_n && evBus.flags[5])
        else $error("unmasked transition missed alert or flag");
    // unmasked sources must both alert and flag
    a_upper_cv_alerts: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent[EV_UPPER_CV] && !mask_ff[EV_UPPER_CV])
            |=> !alert_n && evBus.flags[EV_UPPER_CV])
        else $error("unmasked upper cv missed alert or flag");
    a_lower_cv_alerts: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent[EV_LOWER_CV] && !mask_ff[EV_LOWER_CV])
            |=> !alert_n && evBus.flags[EV_LOWER_CV])
        else $error("unmasked lower cv missed alert or flag");
    a_upper_ov_alerts: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent[EV_UPPER_OV] && !mask_ff[EV_UPPER_OV])
            |=> !alert_n && evBus.flags[EV_UPPER_OV])
        else $error("unmasked upper ov missed alert or flag");
    a_lower_ov_alerts: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent[EV_LOWER_OV] && !mask_ff[EV_LOWER_OV])
            |=> !alert_n && evBus.flags[EV_LOWER_OV])
        else $error("unmasked lower ov missed alert or flag");
    a_overcurrent_alerts: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (evBus.newEvent[EV_OVERCURRENT] && !mask_ff[EV_OVERCURRENT])
            |=> !alert_n && evBus.flags[EV_OVERCURRENT])
        else $error("unmasked overcurrent missed alert or flag");

    // ****************************************************************
    // checks: register port
    // ****************************************************************
    // reserved mask bits never hold a one
    a_mask_bits_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mask_ff[7:6] == 2'h0)
        else $error("reserved mask bits stored");
    // a mask write lands on the next edge
    a_mask_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWrite && regAddr == MASK_ADDR) |=> mask_ff[5:0] == $past(regWdata[5:0]))
        else $error("mask write lost");
    // without a write the mask keeps its value
    a_mask_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(regWrite && regAddr == MASK_ADDR) |=> $stable(mask_ff))
        else $error("mask changed without write");
    // mask read returns the stored bits
    a_mask_read_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regRead && regAddr == MASK_ADDR) |=> regRdata == {2'h0, $past(mask_ff[5:0])})
        else $error("mask read data wrong");
    // flag read returns the flags as they stood before the clear
    a_flag_read_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regRead && regAddr == FLAG_ADDR) |=> regRdata == {2'h0, $past(evBus.flags)})
        else $error("flag read data wrong");
    // other addresses read zero
    a_other_read_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regRead && regAddr != MASK_ADDR && regAddr != FLAG_ADDR) |=> regRdata == 8'h00)
        else $error("unmapped read nonzero");
    // read data stands until the next read
    a_rdata_stands: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !regRead |=> $stable(regRdata))
        else $error("read data changed without read");

    // ****************************************************************
    // checks: event flags
    // ****************************************************************
    // a read with nothing pending leaves all flags clear
    a_flag_read_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (flagReadClr && condLevel == 6'h00 && evBus.newEvent == 6'h00)
            |=> evBus.flags == 6'h00)
        else $error("flags not cleared by read");
    // a held condition other than transition keeps its flag set, reads or not
    a_held_flag_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (condLevel[EV_TRANSITION-1:0] != '0) |=> (evBus.flags[EV_TRANSITION-1:0]
            & $past(condLevel[EV_TRANSITION-1:0])) == $past(condLevel[EV_TRANSITION-1:0]))
        else $error("held condition lost its flag");
    // a change of balancing state always flags
    a_transition_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(balanceActive) |=> evBus.flags[EV_TRANSITION])
        else $error("balance transition not flagged");
endmodule

// ===== tb/cbm_host_model.sv
`timescale 1ns/1ps
// host side of the register port, one strobe per access
module cbm_host_model (
    // clock
    input wire logic clk_sys,
    // register port
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWdata,
    input wire logic [7:0] regRdata
);
    import cbm_pkg::*;
    // idle bus at time zero
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 8'h00;
    end
    // single byte write; data is scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regWdata <= ~d;
    endtask
    // single byte read; flag reads are how the host services events
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        d = regRdata;
    endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import cbm_pkg::*;
    typedef struct {logic [7:0] mask; logic [5:0] cond; logic [7:0] pulses;} cbm_row_s;
    logic clk_sys, rst_n, alert_n, regWrite, regRead;
    logic [7:0] regAddr, regWdata, regRdata, rd, n;
    logic [5:0] cond; // conditions, in flag bit order
    int fails, compares;
    cbm_row_s rows[12];
    cbm_top cbm_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .balanceActive(cond[EV_TRANSITION]), .upperConstVolt(cond[EV_UPPER_CV]),
        .lowerConstVolt(cond[EV_LOWER_CV]), .upperOvervolt(cond[EV_UPPER_OV]),
        .lowerOvervolt(cond[EV_LOWER_OV]), .balanceOvercurrent(cond[EV_OVERCURRENT]),
        .alert_n(alert_n));
    cbm_host_model cbm_host_model_i (.clk_sys(clk_sys), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    // drive conditions, count low cycles of the alert pin over a short window
    task automatic drive(logic [5:0] c, output logic [7:0] cnt);
        cnt = 8'h00;
        @(posedge clk_sys);
        cond <= c;
        repeat (5) begin
            @(negedge clk_sys);
            if (alert_n === 1'b0) cnt++;
        end
    endtask
    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // 50 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // watchdog: whole run is well under 20000 cycles
    initial begin
        #1000000;
        fails++;
        final_report();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        cond = 6'h00;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        check("alert idle", 8'h01, {7'h00, alert_n});
        cbm_host_model_i.rd(MASK_ADDR, rd);
        check("mask reset", 8'h00, rd);
        cbm_host_model_i.wr(MASK_ADDR, 8'hFF);
        cbm_host_model_i.rd(MASK_ADDR, rd);
        check("mask reserved", 8'h3F, rd);
        cbm_host_model_i.rd(8'h00, rd);
        check("unmapped", 8'h00, rd);
        cbm_host_model_i.wr(FLAG_ADDR, 8'hFF);
        cbm_host_model_i.rd(FLAG_ADDR, rd);
        check("flag write", 8'h00, rd);
        // each source alone, once masked, once with only itself open
        for (int i = 0; i < 6; i++) begin
            rows[2*i] = '{8'h01 << i, 6'h01 << i, 8'h00};
            rows[2*i+1] = '{8'h3F ^ (8'h01 << i), 6'h01 << i, 8'h01};
        end
        foreach (rows[k]) begin
            cbm_host_model_i.wr(MASK_ADDR, rows[k].mask);
            drive(rows[k].cond, n);
            check("alert rise", rows[k].pulses, n);
            cbm_host_model_i.rd(FLAG_ADDR, rd);
            check("flag set", {2'b00, rows[k].cond}, rd);
            drive(6'h00, n);
            check("alert fall", rows[k].cond[5] ? rows[k].pulses : 8'h00, n);
            cbm_host_model_i.rd(FLAG_ADDR, rd);
            check("flag after", {2'b00, rows[k].cond}, rd);
            cbm_host_model_i.rd(FLAG_ADDR, rd);
            check("flag clear", 8'h00, rd);
        end
        // held condition re-sets its flag across reads
        cbm_host_model_i.wr(MASK_ADDR, 8'h00);
        drive(6'h04, n);
        cbm_host_model_i.rd(FLAG_ADDR, rd);
        check("held 1", 8'h04, rd);
        cbm_host_model_i.rd(FLAG_ADDR, rd);
        check("held 2", 8'h04, rd);
        drive(6'h00, n);
        // reset in mid-run clears the mask
        cbm_host_model_i.wr(MASK_ADDR, 8'h15);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        cbm_host_model_i.rd(MASK_ADDR, rd);
        check("mask rereset", 8'h00, rd);
        check("alert rereset", 8'h01, {7'h00, alert_n});
        cbm_host_model_i.rd(FLAG_ADDR, rd);
        check("flag rereset", 8'h00, rd);
        final_report();
    end
endmodule
